// File: bench/ssh_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module ssh_cpu_model (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [2:0] tx_count_in,
	input wire logic tx_req_in,
	input wire ssh_pkg::ssh_status_type module_status_in,
	output ssh_pkg::ssh_status_type cpu_status_out
);
	// Registered like a cyclic bus exchange: one cycle behind the module
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			cpu_status_out <= ssh_pkg::STATUS_RESET;
		end else begin
			cpu_status_out.issue_count <= tx_count_in;
			cpu_status_out.open_request <= tx_req_in;
			cpu_status_out.issue_echo <= module_status_in.issue_count;
			cpu_status_out.open_confirm <= module_status_in.open_request;
		end
	end
endmodule // ssh_cpu_model
`default_nettype wire

// File: bench/ssh_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ssh_properties (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire ssh_pkg::ssh_status_type cpu_channel_status_in,
	input wire logic in_send_in,
	input wire logic [ssh_pkg::WIN_BYTES*8-1:0] in_window_in,
	input wire ssh_pkg::ssh_status_type module_channel_status_out,
	input wire logic [ssh_pkg::WIN_BYTES*8-1:0] rx_window_out,
	input wire logic in_ready_out,
	input wire logic msg_end_out,
	input wire logic [ssh_pkg::LEN_W-1:0] msg_len_out,
	input wire logic tx_synced_out,
	input wire logic rx_synced_out
);
	wire ssh_pkg::ssh_status_type ms = module_channel_status_out;
	wire ssh_pkg::ssh_status_type cs = cpu_channel_status_in;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	////////////////////////////////////////////////////////////////
	property p_tx_open;
		tx_synced_out |-> ms.open_confirm;
	endproperty
	a_tx_open: assert property (p_tx_open)
		else $error("tx open without confirm");
	property p_rx_open;
		rx_synced_out |-> ms.open_request;
	endproperty
	a_rx_open: assert property (p_rx_open)
		else $error("rx open without request");
	property p_ready;
		in_ready_out |-> rx_synced_out;
	endproperty
	a_ready: assert property (p_ready)
		else $error("ready while input closed");
	// Guarded by two open cycles so a resync back to zero is not flagged
	property p_step;
		rx_synced_out && $past(rx_synced_out) && $changed(ms.issue_count)
			|-> ms.issue_count == $past(ms.issue_count) + 3'h1;
	endproperty
	a_step: assert property (p_step)
		else $error("input count not a single step");
	property p_take;
		in_send_in && in_ready_out
			|=> !in_ready_out && rx_window_out == $past(in_window_in);
	endproperty
	a_take: assert property (p_take)
		else $error("taken window not loaded");
	property p_echo;
		tx_synced_out && $changed(ms.issue_echo)
			|-> ms.issue_echo == cs.issue_count;
	endproperty
	a_echo: assert property (p_echo)
		else $error("echo differs from cpu count");
	property p_len;
		$changed(msg_len_out) |-> msg_end_out;
	endproperty
	a_len: assert property (p_len)
		else $error("length moved without end");
	property p_req;
		$rose(ms.open_request)
			|-> $past(cs.issue_echo) == $past(ms.issue_count);
	endproperty
	a_req: assert property (p_req)
		else $error("request raised before echo");
endmodule // ssh_properties
`default_nettype wire

// File: bench/ssh_stream_handshake_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ssh_stream_handshake_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] cnt = 3'h0;
	logic req = 1'b0;
	logic snd = 1'b0;
	logic [ssh_pkg::WIN_BYTES*8-1:0] txw = '0;
	logic [ssh_pkg::WIN_BYTES*8-1:0] inw = '0;
	logic [ssh_pkg::WIN_BYTES*8-1:0] rxw;
	ssh_pkg::ssh_status_type cs;
	ssh_pkg::ssh_status_type ms;
	ssh_pkg::ssh_byte_type mb;
	logic rdy, me, md, ts, rs;
	logic [ssh_pkg::LEN_W-1:0] ml;
	int failures = 0;
	int checked = 0;
	always #50 clk = ~clk;
	ssh_cpu_model ssh_cpu_model_i (.core_clk_in(clk), .resetn_in(rstn),
		.tx_count_in(cnt), .tx_req_in(req), .module_status_in(ms),
		.cpu_status_out(cs));
	ssh_stream_handshake ssh_stream_handshake_i (.core_clk_in(clk),
		.resetn_in(rstn), .cpu_channel_status_in(cs), .tx_window_in(txw),
		.in_send_in(snd), .in_window_in(inw),
		.module_channel_status_out(ms), .rx_window_out(rxw),
		.in_ready_out(rdy), .msg_byte_out(mb), .msg_end_out(me),
		.msg_len_out(ml), .msg_discard_out(md), .tx_synced_out(ts),
		.rx_synced_out(rs));
	////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_echo(logic [2:0] e);
		// Never read the status byte in the time step of the edge that moves it
		@(negedge clk);
		for (int i = 0; i < 20 && ms.issue_echo !== e; i++)
			@(negedge clk);
		chk("echo", ms.issue_echo, e);
	endtask
	task automatic test_done;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk("status", ms, 16'h0000);
		chk("flags", {ts, rs, rdy, me, md}, 16'h0000);
	endtask
	task automatic t_open_tx;
		@(posedge clk);
		cnt <= 3'h0;
		req <= 1'b0;
		wait_echo(3'h0);
		// Request goes up with the first step; the confirm must answer it
		for (int k = 1; k <= 2; k++) begin
			chk("early confirm", ms.open_confirm, 16'h0000);
			chk("open w/o confirm", ts, 16'h0000);
			@(posedge clk);
			cnt <= 3'(k);
			req <= 1'b1;
			wait_echo(3'(k));
		end
		for (int i = 0; i < 20 && ms.open_confirm !== 1'b1; i++)
			@(negedge clk);
		chk("confirm", ms.open_confirm, 16'h0001);
		chk("open early", ts, 16'h0000);
		for (int i = 0; i < 20 && ts !== 1'b1; i++)
			@(negedge clk);
		chk("tx open", ts, 16'h0001);
	endtask
	// Payload bytes are counted as they stream out, then held to the end
	task automatic t_msg(logic [2:0] c, logic [63:0] b, logic [15:0] n,
		logic [7:0] last);
		int got;
		logic [7:0] d;
		got = 0;
		d = 8'h00;
		@(posedge clk);
		txw <= {152'h0, b};
		cnt <= c;
		for (int i = 0; i < 80 && me !== 1'b1; i++) begin
			@(negedge clk);
			if (mb.valid === 1'b1) begin
				got++;
				d = mb.data;
			end
		end
		chk("end", me, 16'h0001);
		chk("bytes", got[15:0], n);
		chk("last", {8'h00, d}, {8'h00, last});
		chk("len", ml, n);
		wait_echo(c);
	endtask
	task automatic t_discard;
		@(posedge clk);
		txw <= {152'h0, 64'h0000000033221103};
		cnt <= 3'h6;
		wait_echo(3'h6);
		chk("no end", me, 16'h0000);
		@(posedge clk);
		req <= 1'b0;
		for (int i = 0; i < 20 && md !== 1'b1; i++)
			@(negedge clk);
		chk("discard", md, 16'h0001);
		@(negedge clk);
		chk("tx closed", ts, 16'h0000);
	endtask
	// Input opens while output is closed: directions are independent
	task automatic t_in;
		logic [2:0] c;
		for (int i = 0; i < 40 && rdy !== 1'b1; i++)
			@(negedge clk);
		chk("rx open", {rs, rdy}, 16'h0003);
		for (int k = 0; k < 2; k++) begin
			c = ms.issue_count;
			@(posedge clk);
			snd <= 1'b1;
			inw <= {27{8'h5A ^ 8'(k)}};
			@(posedge clk);
			snd <= 1'b0;
			@(negedge clk);
			chk("rx win", {15'h0, rxw === inw}, 16'h0001);
			chk("rx count", ms.issue_count, c + 3'h1);
			for (int i = 0; i < 20 && rdy !== 1'b1; i++)
				@(negedge clk);
		end
	endtask
	initial begin
		#2000000;
		failures++;
		test_done();
	end
	initial begin
		t_reset();
		t_open_tx();
		t_msg(3'h3, 64'h0000001185AA81, 16'h0001, 8'hAA);
		t_msg(3'h4, 64'h00EEDDCC83BBAA42, 16'h0005, 8'hEE);
		// Empty final segment closes a message already carried in full
		t_msg(3'h5, 64'h0000000080BBAA42, 16'h0002, 8'hBB);
		t_discard();
		t_in();
		test_done();
	end
endmodule // ssh_stream_handshake_tb
bind ssh_stream_handshake ssh_properties ssh_properties_i (
	.core_clk_in(core_clk_in), .resetn_in(resetn_in),
	.cpu_channel_status_in(cpu_channel_status_in), .in_send_in(in_send_in),
	.in_window_in(in_window_in),
	.module_channel_status_out(module_channel_status_out),
	.rx_window_out(rx_window_out), .in_ready_out(in_ready_out),
	.msg_end_out(msg_end_out), .msg_len_out(msg_len_out),
	.tx_synced_out(tx_synced_out), .rx_synced_out(rx_synced_out));
`default_nettype wire

// File: src/ssh_pkg.sv
package ssh_pkg;

	// Enabled window size in bytes, both directions
	localparam int WIN_BYTES = 27;
	localparam int POS_W = 5;
	localparam int LEN_W = 16;

	// Status byte fields
	localparam int ST_COUNT_LSB = 0;
	localparam int ST_REQ_BIT = 3;
	localparam int ST_ECHO_LSB = 4;
	localparam int ST_CONFIRM_BIT = 7;

	// Control octet fields
	localparam int CO_LEN_LSB = 0;
	localparam int CO_PLACE_BIT = 6;
	localparam int CO_FINAL_BIT = 7;

	// Increments the module sees before it confirms the output direction
	localparam logic [1:0] OPEN_INCREMENTS = 2'h2;

	localparam logic [2:0] COUNT_RESET = 3'h0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	typedef struct packed {
		logic open_confirm;
		logic [2:0] issue_echo;
		logic open_request;
		logic [2:0] issue_count;
	} ssh_status_type;

	typedef struct packed {
		logic msg_final_flag;
		logic next_ctrl_place;
		logic [5:0] seg_payload_len;
	} ssh_ctrl_octet_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} ssh_byte_type;

	typedef enum logic [0:0] {TX_MIRROR, TX_OPEN} ssh_tx_state_type;
	typedef enum logic [1:0] {RX_ZERO, RX_ONE, RX_REQ, RX_OPEN}
		ssh_rx_state_type;
	typedef enum logic [0:0] {P_IDLE, P_WALK} ssh_parse_state_type;

endpackage

// File: src/ssh_stream_handshake.sv
`timescale 1ns/100ps
`default_nettype none

module ssh_stream_handshake (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire ssh_pkg::ssh_status_type cpu_channel_status_in,
	input wire logic [ssh_pkg::WIN_BYTES*8-1:0] tx_window_in,
	input wire logic in_send_in,
	input wire logic [ssh_pkg::WIN_BYTES*8-1:0] in_window_in,
	output ssh_pkg::ssh_status_type module_channel_status_out,
	output logic [ssh_pkg::WIN_BYTES*8-1:0] rx_window_out,
	output logic in_ready_out,
	output ssh_pkg::ssh_byte_type msg_byte_out,
	output logic msg_end_out,
	output logic [ssh_pkg::LEN_W-1:0] msg_len_out,
	output logic msg_discard_out,
	output logic tx_synced_out,
	output logic rx_synced_out
);

	////////////////////////////////////////////////////////////////////////
	// Output direction handshake (CPU sends, module receives)

	ssh_pkg::ssh_status_type cpu;
	ssh_pkg::ssh_tx_state_type tx_state;
	ssh_pkg::ssh_tx_state_type next_tx_state;
	logic [2:0] tx_echo;
	logic [2:0] next_tx_echo;
	logic tx_confirm;
	logic next_tx_confirm;
	logic [2:0] tx_ref;
	logic [2:0] next_tx_ref;
	logic [2:0] prev_count;
	logic [1:0] inc_seen;
	logic [1:0] next_inc_seen;
	logic tx_open;
	logic tx_new_seq;
	logic parse_done;

	assign cpu = cpu_channel_status_in;
	assign tx_open = tx_confirm && cpu.open_request;
	// A changed count, not a larger one, so the wrap at eight is harmless
	assign tx_new_seq = tx_open && (cpu.issue_count != tx_ref);

	always_comb begin
		next_tx_state = tx_state;
		next_tx_echo = tx_echo;
		next_tx_confirm = tx_confirm;
		next_tx_ref = tx_ref;
		next_inc_seen = inc_seen;
		case (tx_state)
			ssh_pkg::TX_MIRROR: begin
				next_tx_echo = cpu.issue_count;
				next_tx_confirm = 1'b0;
				if (cpu.issue_count == ssh_pkg::COUNT_RESET &&
					!cpu.open_request) begin
					next_inc_seen = 2'h0;
				end else if (cpu.issue_count == prev_count + 3'h1 &&
					inc_seen != ssh_pkg::OPEN_INCREMENTS) begin
					next_inc_seen = inc_seen + 2'h1;
				end
				if (inc_seen == ssh_pkg::OPEN_INCREMENTS) begin
					next_tx_confirm = 1'b1;
					next_tx_ref = cpu.issue_count;
					next_tx_echo = cpu.issue_count;
					next_tx_state = ssh_pkg::TX_OPEN;
				end
			end
			ssh_pkg::TX_OPEN: begin
				if (!cpu.open_request) begin
					// Partner withdrew: back to mirroring
					next_tx_confirm = 1'b0;
					next_inc_seen = 2'h0;
					next_tx_state = ssh_pkg::TX_MIRROR;
				end else if (parse_done) begin
					next_tx_ref = cpu.issue_count;
					next_tx_echo = cpu.issue_count;
				end
			end
			default: next_tx_state = ssh_pkg::TX_MIRROR;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			tx_state <= ssh_pkg::TX_MIRROR;
			tx_echo <= ssh_pkg::COUNT_RESET;
			tx_confirm <= 1'b0;
			tx_ref <= ssh_pkg::COUNT_RESET;
			prev_count <= ssh_pkg::COUNT_RESET;
			inc_seen <= 2'h0;
		end else begin
			tx_state <= next_tx_state;
			tx_echo <= next_tx_echo;
			tx_confirm <= next_tx_confirm;
			tx_ref <= next_tx_ref;
			prev_count <= cpu.issue_count;
			inc_seen <= next_inc_seen;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Segment walker over one received window

	ssh_pkg::ssh_parse_state_type p_state;
	ssh_pkg::ssh_parse_state_type next_p_state;
	logic [ssh_pkg::WIN_BYTES*8-1:0] win;
	logic [ssh_pkg::POS_W-1:0] pos;
	logic [ssh_pkg::POS_W-1:0] next_pos;
	logic [5:0] seg_left;
	logic [5:0] next_seg_left;
	logic seg_final;
	logic next_seg_final;
	logic seg_place;
	logic next_seg_place;
	logic [ssh_pkg::LEN_W-1:0] acc_len;
	logic [ssh_pkg::LEN_W-1:0] next_acc_len;
	logic [7:0] cur_byte;
	ssh_pkg::ssh_ctrl_octet_type ctrl;
	logic last_pos;
	logic stop_walk;
	logic emit;
	logic commit;
	logic drop;

	assign cur_byte = win[pos*8 +: 8];
	assign ctrl = cur_byte;
	assign last_pos = (pos == ssh_pkg::POS_W'(ssh_pkg::WIN_BYTES - 1));
	assign drop = (tx_state == ssh_pkg::TX_OPEN) && !cpu.open_request;

	always_comb begin
		next_p_state = p_state;
		next_pos = pos;
		next_seg_left = seg_left;
		next_seg_final = seg_final;
		next_seg_place = seg_place;
		next_acc_len = acc_len;
		emit = 1'b0;
		commit = 1'b0;
		stop_walk = 1'b0;
		case (p_state)
			ssh_pkg::P_IDLE: begin
				next_pos = '0;
				if (tx_new_seq) begin
					next_p_state = ssh_pkg::P_WALK;
				end
			end
			ssh_pkg::P_WALK: begin
				if (seg_left != 6'h0) begin
					// Payload byte; a segment may run on into the next window
					emit = 1'b1;
					next_seg_left = seg_left - 6'h1;
					next_acc_len = acc_len + 16'h1;
					if (seg_left == 6'h1) begin
						commit = seg_final;
						stop_walk = !seg_place;
					end
				end else begin
					next_seg_left = ctrl.seg_payload_len;
					next_seg_final = ctrl.msg_final_flag;
					next_seg_place = ctrl.next_ctrl_place;
					if (ctrl.seg_payload_len == 6'h0) begin
						commit = ctrl.msg_final_flag;
						stop_walk = !ctrl.next_ctrl_place;
					end
				end
				if (commit) begin
					next_acc_len = '0;
				end
				next_pos = pos + 5'h1;
				if (stop_walk || last_pos) begin
					next_p_state = ssh_pkg::P_IDLE;
				end
			end
			default: next_p_state = ssh_pkg::P_IDLE;
		endcase
		if (drop) begin
			// Unfinished message is lost; completed ones were already released
			next_p_state = ssh_pkg::P_IDLE;
			next_seg_left = 6'h0;
			next_acc_len = '0;
		end
	end

	assign parse_done = (p_state == ssh_pkg::P_WALK) &&
		(next_p_state == ssh_pkg::P_IDLE) && !drop;

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			p_state <= ssh_pkg::P_IDLE;
			pos <= '0;
			seg_left <= 6'h0;
			seg_final <= 1'b0;
			seg_place <= 1'b0;
			acc_len <= '0;
			win <= '0;
		end else begin
			p_state <= next_p_state;
			pos <= next_pos;
			seg_left <= next_seg_left;
			seg_final <= next_seg_final;
			seg_place <= next_seg_place;
			acc_len <= next_acc_len;
			if (p_state == ssh_pkg::P_IDLE && tx_new_seq) begin
				win <= tx_window_in;
			end
		end
	end

	// Message outputs, registered
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			msg_byte_out <= '0;
			msg_end_out <= 1'b0;
			msg_len_out <= '0;
			msg_discard_out <= 1'b0;
		end else begin
			msg_byte_out.valid <= emit && !drop;
			msg_byte_out.data <= cur_byte;
			msg_end_out <= commit && !drop;
			msg_len_out <= commit ? (emit ? acc_len + 16'h1 : acc_len)
				: msg_len_out;
			msg_discard_out <= drop && (acc_len != '0 || seg_left != 6'h0 ||
				p_state == ssh_pkg::P_WALK);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input direction handshake (module sends, CPU receives)

	ssh_pkg::ssh_rx_state_type rx_state;
	ssh_pkg::ssh_rx_state_type next_rx_state;
	logic [2:0] rx_count;
	logic [2:0] next_rx_count;
	logic rx_req;
	logic next_rx_req;
	logic rx_open;
	logic rx_take;
	logic next_in_ready;

	assign rx_open = rx_req && cpu.open_confirm;
	// Previous sequence must be echoed back before a new one
	assign next_in_ready = (next_rx_state == ssh_pkg::RX_OPEN) &&
		(cpu.issue_echo == next_rx_count) && !rx_take;
	assign rx_take = in_send_in && in_ready_out && rx_open;

	always_comb begin
		next_rx_state = rx_state;
		next_rx_count = rx_count;
		next_rx_req = rx_req;
		case (rx_state)
			ssh_pkg::RX_ZERO: begin
				next_rx_count = ssh_pkg::COUNT_RESET;
				next_rx_req = 1'b0;
				if (cpu.issue_echo == ssh_pkg::COUNT_RESET &&
					!cpu.open_confirm) begin
					next_rx_count = 3'h1;
					next_rx_state = ssh_pkg::RX_ONE;
				end
			end
			ssh_pkg::RX_ONE: begin
				if (cpu.issue_echo == rx_count && !cpu.open_confirm) begin
					next_rx_req = 1'b1;
					next_rx_state = ssh_pkg::RX_REQ;
				end
			end
			ssh_pkg::RX_REQ: begin
				if (cpu.open_confirm) begin
					next_rx_state = ssh_pkg::RX_OPEN;
				end
			end
			ssh_pkg::RX_OPEN: begin
				if (!cpu.open_confirm) begin
					next_rx_req = 1'b0;
					next_rx_state = ssh_pkg::RX_ZERO;
				end else if (rx_take) begin
					next_rx_count = rx_count + 3'h1;
				end
			end
			default: next_rx_state = ssh_pkg::RX_ZERO;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			rx_state <= ssh_pkg::RX_ZERO;
			rx_count <= ssh_pkg::COUNT_RESET;
			rx_req <= 1'b0;
			in_ready_out <= 1'b0;
			rx_window_out <= '0;
		end else begin
			rx_state <= next_rx_state;
			rx_count <= next_rx_count;
			rx_req <= next_rx_req;
			in_ready_out <= next_in_ready;
			if (rx_take) begin
				rx_window_out <= in_window_in;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Module status byte and open flags

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			module_channel_status_out <= ssh_pkg::STATUS_RESET;
			tx_synced_out <= 1'b0;
			rx_synced_out <= 1'b0;
		end else begin
			// Requests low, acknowledgements high
			module_channel_status_out.issue_count <= next_rx_count;
			module_channel_status_out.open_request <= next_rx_req;
			module_channel_status_out.issue_echo <= next_tx_echo;
			module_channel_status_out.open_confirm <= next_tx_confirm;
			tx_synced_out <= tx_open;
			rx_synced_out <= rx_open;
		end
	end

endmodule // ssh_stream_handshake

`default_nettype wire
